/* tvi_consts.svh */
`ifndef TVI_CONSTS_SVH
`define TVI_CONSTS_SVH

// Register byte addresses on the Avalon slave
`define TVI_CTRL_ADDR    4'h0
`define TVI_STATUS_ADDR  4'h4

// Control register field positions
`define TVI_CTRL_SR_BLK  0
`define TVI_CTRL_IR_BLK  1
`define TVI_CTRL_PRL_BLK 2
`define TVI_CTRL_SR_RST  3

// Status register field positions
`define TVI_ST_P6        0
`define TVI_ST_P7        1
`define TVI_ST_P8        2
`define TVI_ST_P9        3
`define TVI_ST_P10       4
`define TVI_ST_SR_BLKD   5
`define TVI_ST_IR_BLKD   6
`define TVI_ST_PRL_BLKD  7
`define TVI_ST_RX_TRIP   8
`define TVI_ST_SEIS      9
`define TVI_ST_ALARM     10

// Reset values
`define TVI_CTRL_RST     3'h0
`define TVI_RDATA_RST    32'h0000_0000

`endif

/* tvi_pkg.sv */
package tvi_pkg;

    // Discrete field inputs, all asynchronous to core_clk
    typedef struct packed {
        logic [2:0] oil_low;
        logic [3:0] valve_closed;
        logic       turb_perm;
        logic       safety_injection_actuation;
        logic [1:0] manual_sw;
        logic [8:0] seis;
        logic [1:0] abnormal;
        logic       board_fault;
        logic [1:0] ir_above;
        logic [3:0] pr_above_p10;
        logic [3:0] pr_above_p8;
        logic [3:0] pr_above_p7;
        logic [1:0] imp_above;
        logic [3:0] loop_low_flow;
        logic [3:0] pump_brk_open;
        logic       pump_uv;
        logic       pump_uf;
        logic       pzr_low_press;
        logic       pzr_high_level;
    } tvi_pins_s;

    // Trip and permissive outputs
    typedef struct packed {
        logic [1:0] rx_trip;
        logic [1:0] main_brk_trip;
        logic [1:0] bypass_brk_trip;
        logic       uv_coil_en;
        logic [1:0] seismic_trip;
        logic       general_alarm;
        logic       sr_trip_en;
        logic       det_hv_on;
        logic       ir_trip_en;
        logic       prl_trip_en;
    } tvi_trip_s;

    typedef enum logic [1:0] {
        SR_ARMED   = 2'b01,
        SR_BLOCKED = 2'b10
    } tvi_sr_e;

    typedef struct packed {
        tvi_pins_s  sync1;
        tvi_pins_s  sync2;
        tvi_sr_e    sr;
        logic       ir_blk;
        logic       prl_blk;
        logic [2:0] blk_sw;
        logic       sr_rst;
        tvi_trip_s  out;
        logic       waitreq;
        logic [31:0] rdata;
    } tvi_state_s;

endpackage

/* tvi_vote.sv */
// The register offsets and the Avalon-MM slave port were decided locally.
module tvi_vote (
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic               ce,
    input  wire tvi_pkg::tvi_pins_s pins,
    output tvi_pkg::tvi_trip_s      trips,
    input  wire logic [3:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest
);
    `include "tvi_consts.svh"

    tvi_pkg::tvi_state_s st;
    tvi_pkg::tvi_state_s next_st;

    // Majority of three
    function automatic logic ge2of3(input logic [2:0] a);
        ge2of3 = (a[0] & a[1]) | (a[0] & a[2]) | (a[1] & a[2]);
    endfunction

    // At least two of four
    function automatic logic ge2of4(input logic [3:0] a);
        ge2of4 = (a[0] & a[1]) | (a[0] & a[2]) | (a[0] & a[3])
               | (a[1] & a[2]) | (a[1] & a[3]) | (a[2] & a[3]);
    endfunction

    // Seismic voting, one 2-of-3 per acceleration direction
    logic [2:0] seis_dir;
    genvar d;
    generate
        for (d = 0; d < 3; d++) begin : g_dir
            assign seis_dir[d] = ge2of3(st.sync2.seis[d*3 +: 3]);
        end
    endgenerate

    // Permissives from synchronized channel comparators
    logic p6;
    logic p7;
    logic p8;
    logic p9;
    logic p10;
    logic p10_clear;
    logic low_power;
    assign p6        = |st.sync2.ir_above;
    assign p10       = ge2of4(st.sync2.pr_above_p10);
    // Three of four below means at most one above
    assign p10_clear = ~p10;
    assign p8        = ge2of4(st.sync2.pr_above_p8);
    assign low_power = ~ge2of4(st.sync2.pr_above_p7)
                     & ~(&st.sync2.imp_above);
    assign p7        = ~low_power;
    assign p9        = st.sync2.turb_perm;

    // Turbine trip, two matrices kept apart so either alone trips
    logic mat_a;
    logic mat_b;
    logic valves_all;
    logic turb_trip;
    assign mat_a      = ge2of3(st.sync2.oil_low);
    assign mat_b      = ge2of3(st.sync2.oil_low);
    assign valves_all = &st.sync2.valve_closed;
    assign turb_trip  = p9 & (mat_a | mat_b | valves_all);

    // Low-power trip group, gated by P-7; P-8 sets the loop flow vote
    logic flow_trip;
    logic brk_trip;
    logic misc_trip;
    logic lp_trip;
    assign flow_trip = p8 ? |st.sync2.loop_low_flow
                          : ge2of4(st.sync2.loop_low_flow);
    assign brk_trip  = ge2of4(st.sync2.pump_brk_open);
    assign misc_trip = st.sync2.pump_uv | st.sync2.pump_uf
                     | st.sync2.pzr_low_press
                     | st.sync2.pzr_high_level;
    assign lp_trip   = p7 & (flow_trip | brk_trip | misc_trip);

    // Other trip sources
    logic man_trip;
    logic seis_trip;
    logic abn_trip;
    logic rx_any;
    assign man_trip  = |st.sync2.manual_sw;
    assign seis_trip = |seis_dir;
    assign abn_trip  = &st.sync2.abnormal;
    // Manual term is ORed last so no gate can mask it
    assign rx_any    = turb_trip | lp_trip | seis_trip | abn_trip
                     | st.sync2.safety_injection_actuation
                     | man_trip;

    // Per-train demands; both trains carry the same vote so either breaker set trips
    logic [1:0] train_rx;
    logic [1:0] train_brk;
    logic [1:0] train_seis;
    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : g_train
            assign train_rx[t]   = rx_any;
            assign train_brk[t]  = rx_any | man_trip;
            assign train_seis[t] = seis_trip;
        end
    endgenerate

    // Read view of the status word
    logic [31:0] status_word;
    always_comb begin
        status_word                   = 32'h0000_0000;
        status_word[`TVI_ST_P6]       = p6;
        status_word[`TVI_ST_P7]       = p7;
        status_word[`TVI_ST_P8]       = p8;
        status_word[`TVI_ST_P9]       = p9;
        status_word[`TVI_ST_P10]      = p10;
        status_word[`TVI_ST_SR_BLKD]  = (st.sr == tvi_pkg::SR_BLOCKED);
        status_word[`TVI_ST_IR_BLKD]  = st.ir_blk;
        status_word[`TVI_ST_PRL_BLKD] = st.prl_blk;
        status_word[`TVI_ST_RX_TRIP]  = st.out.rx_trip[0];
        status_word[`TVI_ST_SEIS]     = st.out.seismic_trip[0];
        status_word[`TVI_ST_ALARM]    = st.out.general_alarm;
    end

    // Next-state logic for the whole block
    always_comb begin
        next_st        = st;
        // Two stages before any voting logic reads an input
        next_st.sync1  = pins;
        next_st.sync2  = st.sync1;
        next_st.sr_rst = 1'b0;

        // Avalon slave: one wait cycle, then the request completes
        next_st.waitreq = ~((avs_read | avs_write) & st.waitreq);
        if (avs_read && st.waitreq) begin
            next_st.rdata = 32'h0000_0000;
            if (avs_address == `TVI_CTRL_ADDR) begin
                next_st.rdata[2:0] = st.blk_sw;
            end else if (avs_address == `TVI_STATUS_ADDR) begin
                next_st.rdata = status_word;
            end
        end

        // Source range block, only with P-6, held above P-10
        unique case (st.sr)
            tvi_pkg::SR_ARMED: begin
                if (p6 && st.blk_sw[`TVI_CTRL_SR_BLK]) begin
                    next_st.sr = tvi_pkg::SR_BLOCKED;
                end
            end
            tvi_pkg::SR_BLOCKED: begin
                if (!p10 && (!p6 || st.sr_rst)) begin
                    next_st.sr = tvi_pkg::SR_ARMED;
                    // Drop the switch too, else it re-blocks at once
                    next_st.blk_sw[`TVI_CTRL_SR_BLK] = 1'b0;
                end
            end
        endcase

        // Writes land only on the edge where waitrequest is seen low
        // Placed after the re-arm so a switch set in the same cycle wins
        if (avs_write && !st.waitreq) begin
            if (avs_address == `TVI_CTRL_ADDR) begin
                next_st.blk_sw = avs_writedata[`TVI_CTRL_PRL_BLK:`TVI_CTRL_SR_BLK];
                next_st.sr_rst = avs_writedata[`TVI_CTRL_SR_RST];
            end
        end

        // Independent IR and low power-range blocks
        next_st.ir_blk  = (st.ir_blk | (st.blk_sw[`TVI_CTRL_IR_BLK] & p10))
                        & ~p10_clear;
        next_st.prl_blk = (st.prl_blk | (st.blk_sw[`TVI_CTRL_PRL_BLK] & p10))
                        & ~p10_clear;

        // Registered trip outputs
        next_st.out.rx_trip         = train_rx;
        next_st.out.main_brk_trip   = train_brk;
        next_st.out.bypass_brk_trip = train_brk;
        next_st.out.uv_coil_en      = ~(rx_any | man_trip);
        next_st.out.seismic_trip    = train_seis;
        next_st.out.general_alarm   = st.sync2.board_fault;
        next_st.out.sr_trip_en      = (next_st.sr == tvi_pkg::SR_ARMED);
        next_st.out.det_hv_on       = (next_st.sr == tvi_pkg::SR_ARMED);
        next_st.out.ir_trip_en      = ~next_st.ir_blk;
        next_st.out.prl_trip_en     = ~next_st.prl_blk;
    end

    // State register; clock enable freezes everything except the synchronous reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st                 <= '0;
            st.sr              <= tvi_pkg::SR_ARMED;
            st.blk_sw          <= `TVI_CTRL_RST;
            st.waitreq         <= 1'b1;
            st.rdata           <= `TVI_RDATA_RST;
            st.out.uv_coil_en  <= 1'b1;
            st.out.sr_trip_en  <= 1'b1;
            st.out.det_hv_on   <= 1'b1;
            st.out.ir_trip_en  <= 1'b1;
            st.out.prl_trip_en <= 1'b1;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign trips           = st.out;
    assign avs_readdata    = st.rdata;
    assign avs_waitrequest = st.waitreq;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_turb_oil_trip: assert property (
        ce && p9 && (mat_a || mat_b) |=> trips.rx_trip == 2'b11)
        else $error("oil vote with P-9 did not trip");

    a_valve_trip: assert property (
        ce && p9 && valves_all |=> trips.rx_trip == 2'b11)
        else $error("stop valve closure with P-9 did not trip");

    a_turb_supp: assert property (
        ce && !p9 && !lp_trip && !seis_trip && !abn_trip && !man_trip
        && !st.sync2.safety_injection_actuation
        |=> trips.rx_trip == 2'b00)
        else $error("turbine trip passed below P-9");

    a_si_trip: assert property (
        ce && st.sync2.safety_injection_actuation
        |=> trips.rx_trip == 2'b11 && !trips.uv_coil_en)
        else $error("safety injection did not trip");

    a_manual_path: assert property (
        ce && man_trip |=> trips.main_brk_trip == 2'b11
        && trips.bypass_brk_trip == 2'b11 && !trips.uv_coil_en)
        else $error("manual trip missed a breaker");

    a_seis_trip: assert property (
        ce && seis_dir != 3'h0 |=> trips.seismic_trip == 2'b11
        && trips.rx_trip == 2'b11)
        else $error("seismic vote did not trip");

    a_abn_trip: assert property (
        ce && abn_trip |=> trips.rx_trip == 2'b11)
        else $error("dual abnormal did not trip");

    a_board_alarm: assert property (
        ce && st.sync2.board_fault |=> trips.general_alarm)
        else $error("board fault gave no alarm");

    a_sr_auto_rearm: assert property (
        ce && st.sr == tvi_pkg::SR_BLOCKED && !p6 && !p10
        |=> st.sr == tvi_pkg::SR_ARMED && trips.det_hv_on)
        else $error("source range not re-armed below P-6");

    a_sr_hold_p10: assert property (
        ce && st.sr == tvi_pkg::SR_BLOCKED && p10
        |=> st.sr == tvi_pkg::SR_BLOCKED && !trips.det_hv_on)
        else $error("source range block lost above P-10");

    a_blk_need_p10: assert property (
        ce && !st.ir_blk && !p10 |=> !st.ir_blk && trips.ir_trip_en)
        else $error("IR block taken without P-10");

    a_blk_autoclr: assert property (
        ce && p10_clear |=> !st.ir_blk && !st.prl_blk)
        else $error("blocks not cleared below P-10");

    a_lp_blocked: assert property (
        ce && !p7 && !turb_trip && !seis_trip && !abn_trip && !man_trip
        && !st.sync2.safety_injection_actuation
        |=> trips.rx_trip == 2'b00)
        else $error("low-power trip passed without P-7");

    a_single_loop: assert property (
        !p8 && $countones(st.sync2.loop_low_flow) == 1 |-> !flow_trip)
        else $error("single loop tripped without P-8");

    a_sync_delay: assert property (
        ce && pins.safety_injection_actuation ##1 ce [*2]
        |=> trips.rx_trip == 2'b11)
        else $error("input to trip latency not three edges");

    // Blocks and permissives must never mask the manual path
    a_manual_unmasked: assert property (
        ce && man_trip && (st.ir_blk || st.prl_blk || !p7 || !p9
        || st.sr == tvi_pkg::SR_BLOCKED)
        |=> trips.rx_trip == 2'b11 && trips.main_brk_trip == 2'b11)
        else $error("manual trip masked by a block or permissive");

    a_uv_rest: assert property (
        ce && !rx_any |=> trips.uv_coil_en && trips.main_brk_trip == 2'b00
        && trips.bypass_brk_trip == 2'b00)
        else $error("breaker or coil tripped with no demand");

    a_no_cause: assert property (
        ce && !mat_a && !mat_b && !valves_all && !lp_trip && !seis_trip && !abn_trip
        && !man_trip && !st.sync2.safety_injection_actuation
        |=> trips.rx_trip == 2'b00)
        else $error("reactor trip with no voted cause");

    a_seis_quiet: assert property (
        ce && seis_dir == 3'h0 |=> trips.seismic_trip == 2'b00)
        else $error("seismic trip without a two sensor vote");

    // Permissive and block handling
    a_sr_need_p6: assert property (
        ce && st.sr == tvi_pkg::SR_ARMED && !p6
        |=> st.sr == tvi_pkg::SR_ARMED && trips.sr_trip_en)
        else $error("source range blocked without P-6");

    a_sr_manual_rst: assert property (
        ce && st.sr == tvi_pkg::SR_BLOCKED && !p10 && st.sr_rst
        |=> st.sr == tvi_pkg::SR_ARMED && trips.det_hv_on)
        else $error("manual reset did not re-arm source range");

    a_prl_need_p10: assert property (
        ce && !st.prl_blk && !p10 |=> !st.prl_blk && trips.prl_trip_en)
        else $error("low power-range block taken without P-10");

    a_blk_indep: assert property (
        ce && !st.prl_blk && !st.blk_sw[`TVI_CTRL_PRL_BLK] |=> !st.prl_blk)
        else $error("low power-range block followed the IR switch");

    a_low_power: assert property (
        p7 == ($countones(st.sync2.pr_above_p7) >= 2 || st.sync2.imp_above == 2'b11))
        else $error("P-7 does not match flux and impulse votes");

    a_two_loop: assert property (
        ce && p7 && !p8 && $countones(st.sync2.loop_low_flow) >= 2
        |=> trips.rx_trip == 2'b11)
        else $error("two-loop low flow did not trip");

    // Bus handshake and clock enable
    a_bus_one_wait: assert property (
        ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one wait cycle");

    a_bus_release: assert property (
        ce && !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest held low past one cycle");

    a_ce_freeze: assert property (
        !ce |=> $stable(trips) && $stable(avs_readdata) && $stable(avs_waitrequest))
        else $error("state moved while clock enable was low");

    // Coverage of the main scenarios

    c_manual: cover property (ce && man_trip ##1 trips.uv_coil_en == 1'b0);
    c_sr_block: cover property (st.sr == tvi_pkg::SR_BLOCKED);
    c_ir_only: cover property (st.ir_blk && !st.prl_blk);
    c_two_loop: cover property (p7 && !p8 && flow_trip);
    c_ce_hold: cover property (!ce ##1 !ce);

endmodule

/* tvi_field.sv */
// Far side: comparators, switches and seismic sensors feeding the voter
module tvi_field #(
    parameter int HOLD = 12
) (
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire tvi_pkg::tvi_pins_s req,
    input  wire logic [8:0]         seis_hit,
    output tvi_pkg::tvi_pins_s      pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] hold_cnt [9];

    // Seismic exceedance stretch; 6 to 20 s scaled down to HOLD cycles
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 9; i++) begin
            if (!rst_n)
                hold_cnt[i] <= 8'h00;
            else if (seis_hit[i])
                hold_cnt[i] <= 8'(HOLD);
            else if (hold_cnt[i] != 8'h00)
                hold_cnt[i] <= hold_cnt[i] - 8'h01;
        end
    end

    // Plain levels pass straight through; seismic bits come from the stretch
    always_comb begin
        pins = req;
        for (int i = 0; i < 9; i++)
            pins.seis[i] = (hold_cnt[i] != 8'h00);
    end
endmodule

/* tvi_vote_bench.sv */
module tvi_vote_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HOLD = 12;
    logic               core_clk, rst_n, ce;
    tvi_pkg::tvi_pins_s req, p, pins;
    tvi_pkg::tvi_trip_s trips, e;
    logic [8:0]         seis_hit;
    logic [3:0]         avs_address;
    logic               avs_read, avs_write, avs_waitrequest;
    logic [31:0]        avs_writedata, avs_readdata, rd;
    int                 error_cnt = 0;
    int                 cmp_count = 0;

    tvi_field #(.HOLD(HOLD)) field_u (.core_clk(core_clk), .rst_n(rst_n), .req(req),
        .seis_hit(seis_hit), .pins(pins));
    tvi_vote dut_u (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .pins(pins), .trips(trips),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    // 20 MHz system clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task chk(input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, s, x);
        end
    endtask

    task test_done;
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Sampled off the edge so the output register update has landed
    task settle;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task put(input tvi_pkg::tvi_pins_s v);
        @(posedge core_clk);
        req <= v;
        settle();
    endtask

    // Avalon master: hold everything until waitrequest is seen low
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        chk(n, 2);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        settle();
    endtask

    task t_regs;
        e = '0;
        {e.uv_coil_en, e.sr_trip_en, e.det_hv_on, e.ir_trip_en, e.prl_trip_en} = 5'h1F;
        chk(trips, e);
        bus(1, 4'h8, 32'hFFFF_FFFF);
        bus(0, 4'h8, '0);
        chk(rd, 0);
        bus(1, 4'h0, 32'hFFFF_FFFE);
        bus(0, 4'h0, '0);
        chk(rd, 6);
        bus(0, 4'h4, '0);
        chk(rd, 0);
        bus(1, 4'h0, 0);
    endtask

    // Every 2-of-3 pair trips, a single sensor does not
    task t_turb;
        logic [2:0] pat [4];
        pat = '{3'b011, 3'b101, 3'b110, 3'b001};
        for (int i = 0; i < 4; i++) begin
            p = '0;
            p.oil_low = pat[i];
            p.turb_perm = 1'b1;
            put(p);
            chk(trips.rx_trip, (i < 3) ? 3 : 0);
        end
        p.oil_low = 3'b111;
        p.turb_perm = 1'b0;
        put(p);
        chk(trips.rx_trip, 0);
        p = '0;
        p.valve_closed = 4'hF;
        put(p);
        chk(trips.rx_trip, 0);
        p.turb_perm = 1'b1;
        put(p);
        chk(trips.rx_trip, 3);
        p.valve_closed = 4'h7;
        put(p);
        chk(trips.rx_trip, 0);
        p = '0;
        p.safety_injection_actuation = 1'b1;
        put(p);
        chk(trips.rx_trip, 3);
    endtask

    // Manual path with the IR and low power-range block switches set, latency counted edge by edge
    task t_manual;
        put('0); // Inputs left asserted would spoil the three-edge latency check
        bus(1, 4'h0, 32'h6);
        for (int i = 0; i < 2; i++) begin
            p = '0;
            p.manual_sw = 2'(1 << i);
            @(posedge core_clk);
            req <= p;
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            chk(trips.main_brk_trip, 0);
            @(negedge core_clk);
            chk(trips.main_brk_trip, 3);
            chk(trips.bypass_brk_trip, 3);
            chk(trips.uv_coil_en, 0);
            put('0);
            chk(trips.uv_coil_en, 1);
        end
        bus(1, 4'h0, 0);
    endtask

    task t_seis;
        for (int d = 0; d < 3; d++) begin
            for (int k = 0; k < 2; k++) begin
                @(posedge core_clk);
                seis_hit <= (k == 0) ? 9'(9'h5 << (3 * d)) : 9'(9'h1 << (3 * d));
                @(posedge core_clk);
                seis_hit <= '0;
                settle();
                chk(trips.seismic_trip, (k == 0) ? 3 : 0);
                repeat (HOLD + 4) @(posedge core_clk);
                @(negedge core_clk);
                chk(trips.seismic_trip, 0);
            end
        end
    endtask

    task t_abn;
        p = '0;
        p.abnormal = 2'b01;
        put(p);
        chk(trips.rx_trip, 0);
        p.abnormal = 2'b11;
        put(p);
        chk(trips.rx_trip, 3);
        p = '0;
        p.board_fault = 1'b1;
        put(p);
        chk(trips.general_alarm, 1);
    endtask

    task t_sr;
        put('0);
        bus(1, 4'h0, 1);
        chk(trips.sr_trip_en, 1);
        p = '0;
        p.ir_above = 2'b01;
        put(p);
        bus(1, 4'h0, 1);
        chk({trips.sr_trip_en, trips.det_hv_on}, 0);
        bus(0, 4'h4, '0);
        chk(rd[7:0], 8'h21);
        put('0);
        chk({trips.sr_trip_en, trips.det_hv_on}, 3);
        p.ir_above = 2'b11;
        p.pr_above_p10 = 4'b0011;
        put(p);
        bus(1, 4'h0, 1);
        bus(1, 4'h0, 8);
        chk({trips.sr_trip_en, trips.det_hv_on}, 0);
        p.pr_above_p10 = 4'b0000;
        put(p);
        chk(trips.sr_trip_en, 0);
        bus(1, 4'h0, 8);
        chk({trips.sr_trip_en, trips.det_hv_on}, 3);
    endtask

    task t_ir;
        p = '0;
        p.pr_above_p10 = 4'b0001;
        put(p);
        bus(1, 4'h0, 2);
        chk(trips.ir_trip_en, 1);
        p.pr_above_p10 = 4'b0101;
        put(p);
        chk({trips.ir_trip_en, trips.prl_trip_en}, 1);
        bus(1, 4'h0, 6);
        chk(trips.prl_trip_en, 0);
        p.pr_above_p10 = 4'b0100;
        put(p);
        chk({trips.ir_trip_en, trips.prl_trip_en}, 3);
        bus(1, 4'h0, 0);
    endtask

    // Each of the four pump and pressurizer trips against three flux and impulse combinations
    task t_lowpwr;
        for (int k = 0; k < 4; k++) begin
            p = '0;
            {p.pump_uv, p.pump_uf, p.pzr_low_press, p.pzr_high_level} = 4'(4'h8 >> k);
            p.pr_above_p7 = 4'b0001;
            p.imp_above = 2'b01;
            put(p);
            chk(trips.rx_trip, 0);
            p.imp_above = 2'b11;
            put(p);
            chk(trips.rx_trip, 3);
            p.imp_above = 2'b00;
            p.pr_above_p7 = 4'b0011;
            put(p);
            chk(trips.rx_trip, 3);
        end
    endtask

    task t_flow;
        logic [3:0] lf [5];
        logic [3:0] p8 [5];
        logic [1:0] im [5];
        logic [1:0] x [5];
        lf = '{4'b0001, 4'b0101, 4'b0001, 4'b0101, 4'b0000};
        p8 = '{4'b0000, 4'b0000, 4'b0011, 4'b0000, 4'b0000};
        im = '{2'b11, 2'b11, 2'b11, 2'b00, 2'b11};
        x = '{2'b00, 2'b11, 2'b11, 2'b00, 2'b00};
        for (int i = 0; i < 5; i++) begin
            p = '0;
            p.loop_low_flow = lf[i];
            p.pr_above_p8 = p8[i];
            p.imp_above = im[i];
            p.pump_brk_open = (i == 4) ? 4'b0001 : 4'b0000;
            put(p);
            chk(trips.rx_trip, x[i]);
        end
        p.pump_brk_open = 4'b1001;
        put(p);
        chk(trips.rx_trip, 3);
    endtask

    // Clock enable low must freeze the pipeline against a live trip input
    task t_ce;
        put('0);
        p = '0;
        p.safety_injection_actuation = 1'b1;
        @(posedge core_clk);
        ce <= 1'b0;
        put(p);
        chk(trips.rx_trip, 0);
        @(posedge core_clk);
        ce <= 1'b1;
        settle();
        chk(trips.rx_trip, 3);
        put('0);
        chk(trips.rx_trip, 0);
    endtask

    // Watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        test_done();
    end

    initial begin
        ce = 1'b1;
        rst_n = 1'b0;
        req = '0;
        seis_hit = '0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        t_regs();
        t_turb();
        t_manual();
        t_seis();
        t_abn();
        t_sr();
        t_ir();
        t_lowpwr();
        t_flow();
        t_ce();
        test_done();
    end
endmodule
